// File: design/actm_pkg.sv
// Constants and types shared by the converter control block
package actm_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CON1 = 8'hE2;
  localparam logic [7:0] ADDR_CON2 = 8'hE3;
  localparam logic [7:0] ADDR_BUFL = 8'hE4;
  localparam logic [7:0] ADDR_BUFH = 8'hE5;
  localparam logic [7:0] ADDR_THRL = 8'hE6;
  localparam logic [7:0] ADDR_THRH = 8'hE7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_HI_CLR   = 7;
  localparam int C1_LO_CLR   = 5;
  localparam int C1_INV      = 3;
  localparam int C1_VREF     = 2;
  localparam int C1_CONT     = 1;
  localparam int C1_START    = 0;
  localparam int C2_JUST     = 7;
  localparam int C2_RATE_LSB = 4;
  localparam int C2_THA      = 3;
  localparam int C2_THB      = 2;
  localparam int C2_AUTO     = 1;
  localparam int C2_INSEL    = 0;

  // ----------------------------------------------------------------
  // Converter and timing
  // ----------------------------------------------------------------
  localparam int          RESULT_W        = 10;
  localparam int          CONV_MAX_CYCLES = 156;
  localparam int          BIT_CYCLES      = 15;
  localparam int          DIV_W           = 14;
  localparam logic [13:0] DIV_8832        = 14'h2280;
  localparam logic [13:0] DIV_4416        = 14'h1140;
  localparam logic [13:0] DIV_2208        = 14'h08A0;
  localparam logic [13:0] DIV_1104        = 14'h0450;
  localparam logic [13:0] DIV_552         = 14'h0228;

  typedef enum logic [0:0] {
    ACTM_SAR_IDLE = 1'b0,
    ACTM_SAR_RUN  = 1'b1
  } actm_sar_state_t;

endpackage : actm_pkg

// File: design/actm_sar_if.sv
// Handshake between control logic and the approximation engine
`timescale 1ns/1ps
interface actm_sar_if;
  import actm_pkg::*;
  logic                start;
  logic                busy;
  logic                done;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] dac_code;
  modport ctrl (output start, input busy, done, result, dac_code);
  modport conv (input start, output busy, done, result, dac_code);
endinterface : actm_sar_if

// File: design/actm_sar.sv
// Successive approximation engine
`timescale 1ns/1ps
module actm_sar
  import actm_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic cmp_in,
  actm_sar_if.conv  sar
);

  if (BIT_CYC < 1 ||
      RESULT_W * BIT_CYC + 2 > CONV_MAX_CYCLES) begin : g_bad_cyc
    $error("actm_sar: BIT_CYC too large for conversion time");
  end

  typedef struct packed {
    actm_sar_state_t     state;
    logic [3:0]          bit_idx;
    logic [7:0]          tick;
    logic [RESULT_W-1:0] code;
    logic [RESULT_W-1:0] result;
    logic                busy;
    logic                done;
    logic                cmp_m;
    logic                cmp_s;
  } actm_sar_st_t;

  actm_sar_st_t s_q;
  actm_sar_st_t s_d;

  // ----------------------------------------------------------------
  // Bit trial sequence
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.cmp_m = cmp_in;
    s_d.cmp_s = s_q.cmp_m;
    unique case (s_q.state)
      ACTM_SAR_IDLE: begin
        if (sar.start) begin
          s_d.state   = ACTM_SAR_RUN;
          s_d.bit_idx = 4'(RESULT_W - 1);
          s_d.tick    = 8'h00;
          s_d.code    = 10'h200;
          s_d.busy    = 1'b1;
        end
      end
      ACTM_SAR_RUN: begin
        s_d.tick = s_q.tick + 8'h01;
        if (s_q.tick == 8'(BIT_CYC - 1)) begin
          s_d.tick = 8'h00;
          if (!s_q.cmp_s) begin
            s_d.code[s_q.bit_idx] = 1'b0;
          end
          if (s_q.bit_idx == 4'h0) begin
            s_d.result = s_d.code;
            s_d.done   = 1'b1;
            s_d.busy   = 1'b0;
            s_d.state  = ACTM_SAR_IDLE;
          end else begin
            s_d.bit_idx = s_q.bit_idx - 4'h1;
            s_d.code[s_d.bit_idx] = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sar.busy     = s_q.busy;
  assign sar.done     = s_q.done;
  assign sar.result   = s_q.result;
  assign sar.dac_code = s_q.code;

endmodule : actm_sar

// File: design/actm_top.sv
// Converter control registers, scheduling and threshold monitor
//
// How it works
// - Ten-bit unsigned approximation result from one of two inputs, kept in two bytes.
// - Single conversions on command and continuous conversions at selectable rate.
// - Writing one to bit 7 clears high flag; bit 7 reads zero.
// - Writing one to bit 5 clears low flag; bit 5 reads zero.
// - At conversion end result bits 9-2 compared with upper limit.
// - At conversion end result bits 9-2 compared with lower limit.
// - Either flag set drives the shared active-low request line low.
// - Normal mode: high flag above upper limit, low flag below lower limit.
// - Inverted mode: both flags when result inside the inclusive window.
// - Bit 2 picks bandgap reference, zero uses supply reference.
// - Bit 1 enables repeated conversions at the secondary register rate.
// - Primary control register clears to zero on reset.
// - Bit 0 write one starts; reads busy; done within 156 clocks.
// - Rate codes divide clock by 8832/4416/2208/1104, even codes by 552.
// - Justify bit aligns result left or right, spare bits zero.
// - Input select bit picks first input at zero, second at one.
`timescale 1ns/1ps
module actm_top
  import actm_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata,
  input  wire logic                cmp_in,
  output logic      [RESULT_W-1:0] dac_code,
  output logic                     hold_active,
  output logic                     input_second_sel,
  output logic                     ref_bandgap_sel,
  output logic                     th_a_en,
  output logic                     th_b_en,
  output logic                     limit_irq_line_n
);

  typedef struct packed {
    logic                hi;
    logic                lo;
    logic                inv;
    logic                vref;
    logic                cont;
    logic                busy;
    logic [7:0]          con2;
    logic [7:0]          thrl;
    logic [7:0]          thrh;
    logic [RESULT_W-1:0] result;
    logic [DIV_W-1:0]    div_cnt;
    logic                start;
    logic [7:0]          rdata;
    logic                irq_n;
    logic                th_a;
    logic                th_b;
  } actm_st_t;

  actm_st_t r_q;
  actm_st_t r_d;
  actm_sar_if sar_bus ();

  logic [DIV_W-1:0] div_sel;
  logic [7:0]       res8;
  logic             wr_c1;
  logic             wr_c2;
  logic             wr_thl;
  logic             wr_thh;
  logic             clr_hi;
  logic             clr_lo;
  logic             ths_off;
  logic             hi_set;
  logic             lo_set;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (BIT_CYC < 1 ||
      RESULT_W * BIT_CYC + 2 > CONV_MAX_CYCLES) begin : g_bad_cyc
    $error("actm_top: BIT_CYC too large for conversion time");
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign wr_c1  = sfr_wr && (sfr_addr == ADDR_CON1);
  assign wr_c2  = sfr_wr && (sfr_addr == ADDR_CON2);
  assign wr_thl = sfr_wr && (sfr_addr == ADDR_THRL);
  assign wr_thh = sfr_wr && (sfr_addr == ADDR_THRH);
  assign clr_hi = wr_c1 && sfr_wdata[C1_HI_CLR];
  assign clr_lo = wr_c1 && sfr_wdata[C1_LO_CLR];

  // ----------------------------------------------------------------
  // Rate selection and threshold compare
  // ----------------------------------------------------------------
  always_comb begin
    div_sel = DIV_552;
    if (r_q.con2[C2_RATE_LSB]) begin
      unique case (r_q.con2[C2_RATE_LSB+2 -: 2])
        2'b00: div_sel = DIV_8832;
        2'b01: div_sel = DIV_4416;
        2'b10: div_sel = DIV_2208;
        2'b11: div_sel = DIV_1104;
      endcase
    end
    res8   = sar_bus.result[RESULT_W-1 -: 8];
    hi_set = 1'b0;
    lo_set = 1'b0;
    if (sar_bus.done) begin
      if (r_q.inv) begin
        hi_set = (res8 <= r_q.thrh) && (res8 >= r_q.thrl);
        lo_set = hi_set;
      end else begin
        hi_set = res8 > r_q.thrh;
        lo_set = res8 < r_q.thrl;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file and control
  // ----------------------------------------------------------------
  always_comb begin
    r_d       = r_q;
    r_d.start = 1'b0;
    if (wr_c1) begin
      r_d.inv  = sfr_wdata[C1_INV];
      r_d.vref = sfr_wdata[C1_VREF];
      r_d.cont = sfr_wdata[C1_CONT];
      if (sfr_wdata[C1_START] && !r_q.busy) begin
        r_d.start = 1'b1;
        r_d.busy  = 1'b1;
      end
    end
    if (wr_c2) begin
      r_d.con2 = sfr_wdata;
    end
    if (wr_thl) begin
      r_d.thrl = sfr_wdata;
    end
    if (wr_thh) begin
      r_d.thrh = sfr_wdata;
    end
    if (r_q.cont) begin
      r_d.div_cnt = r_q.div_cnt + 14'h0001;
      if (r_q.div_cnt >= div_sel - 14'h0001) begin
        r_d.div_cnt = '0;
        if (!r_q.busy && !r_d.start) begin
          r_d.start = 1'b1;
          r_d.busy  = 1'b1;
        end
      end
    end else begin
      r_d.div_cnt = '0;
    end
    if (sar_bus.done) begin
      r_d.busy   = 1'b0;
      r_d.result = sar_bus.result;
    end
    r_d.hi = (r_q.hi & ~clr_hi) | hi_set;
    r_d.lo = (r_q.lo & ~clr_lo) | lo_set;
    r_d.irq_n = ~(r_d.hi | r_d.lo);
    ths_off   = r_q.con2[C2_AUTO] & r_q.cont & ~r_d.busy;
    r_d.th_a  = r_q.con2[C2_THA] & ~ths_off;
    r_d.th_b  = r_q.con2[C2_THB] & ~ths_off;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CON1: r_d.rdata = {1'b0, r_q.hi, 1'b0, r_q.lo, r_q.inv,
                                r_q.vref, r_q.cont, r_q.busy};
        ADDR_CON2: r_d.rdata = r_q.con2;
        ADDR_BUFL: r_d.rdata = r_q.con2[C2_JUST] ?
                               r_q.result[7:0] :
                               {r_q.result[1:0], 6'h00};
        ADDR_BUFH: r_d.rdata = r_q.con2[C2_JUST] ?
                               {6'h00, r_q.result[9:8]} :
                               r_q.result[9:2];
        ADDR_THRL: r_d.rdata = r_q.thrl;
        ADDR_THRH: r_d.rdata = r_q.thrh;
        default:   r_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r_q       <= '0;
      r_q.irq_n <= 1'b1;
      r_q.con2  <= REG_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Engine and outputs
  // ----------------------------------------------------------------
  assign sar_bus.start = r_q.start;

  actm_sar #(
    .BIT_CYC (BIT_CYC)
  ) u_sar (
    .clock   (clock),
    .reset_n (reset_n),
    .cmp_in  (cmp_in),
    .sar     (sar_bus.conv)
  );

  assign sfr_rdata        = r_q.rdata;
  assign dac_code         = sar_bus.dac_code;
  assign hold_active      = sar_bus.busy;
  assign input_second_sel = r_q.con2[C2_INSEL];
  assign ref_bandgap_sel  = r_q.vref;
  assign th_a_en          = r_q.th_a;
  assign th_b_en          = r_q.th_b;
  assign limit_irq_line_n = r_q.irq_n;

endmodule : actm_top

// File: test/actm_afe.sv
// Analogue front end model: two inputs and a comparator on the trial code
`timescale 1ns/1ps
module actm_afe
  import actm_pkg::*;
(
  input  wire logic [RESULT_W-1:0] vin_a,
  input  wire logic [RESULT_W-1:0] vin_b,
  input  wire logic [RESULT_W-1:0] dac_code,
  input  wire logic                input_second_sel,
  input  wire logic                hold_active,
  output logic                     cmp_in
);
  logic [RESULT_W-1:0] vin_sel;
  assign vin_sel = input_second_sel ? vin_b : vin_a;
  assign cmp_in = hold_active ? (vin_sel >= dac_code) : dac_code[0];
endmodule : actm_afe

// File: test/actm_asserts.sv
// Assertion checker on the converter control top ports
`timescale 1ns/1ps
module actm_asserts
  import actm_pkg::*;
(
  input wire logic                clock,
  input wire logic                reset_n,
  input wire logic [7:0]          sfr_addr,
  input wire logic                sfr_wr,
  input wire logic                sfr_rd,
  input wire logic [7:0]          sfr_wdata,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                cmp_in,
  input wire logic [RESULT_W-1:0] dac_code,
  input wire logic                hold_active,
  input wire logic                input_second_sel,
  input wire logic                ref_bandgap_sel,
  input wire logic                th_a_en,
  input wire logic                th_b_en,
  input wire logic                limit_irq_line_n
);
  logic c1;
  logic c2;
  assign c1 = sfr_addr == ADDR_CON1;
  assign c2 = sfr_addr == ADDR_CON2;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_rd1;
    sfr_rd && c1;
  endsequence
  sequence s_w1_alone;
    sfr_wr && c1 ##1 !(sfr_wr && c1);
  endsequence
  sequence s_w2_alone;
    sfr_wr && c2 ##1 !(sfr_wr && c2);
  endsequence
  AST_CLR_BITS_ZERO: assert property (
    s_rd1 |=> !sfr_rdata[7] && !sfr_rdata[5])
    else $error("clear bit read as one");
  AST_IRQ_MATCH: assert property (
    s_rd1 |=> (sfr_rdata[6] | sfr_rdata[4]) == !$past(limit_irq_line_n))
    else $error("request line disagrees with flags");
  AST_IRQ_LEVEL: assert property (
    !limit_irq_line_n && !(sfr_wr && c1 && (sfr_wdata[7] | sfr_wdata[5]))
    |=> !limit_irq_line_n)
    else $error("request released without clear");
  AST_IRQ_AT_END: assert property (
    $fell(limit_irq_line_n)
    |-> hold_active || $past(hold_active) || $past(hold_active, 2))
    else $error("request raised away from conversion end");
  AST_START_HOLD: assert property (
    sfr_wr && c1 && sfr_wdata[0] && !hold_active && !$past(hold_active)
    |-> ##[1:3] hold_active)
    else $error("start did not begin a conversion");
  AST_CONV_BOUND: assert property (
    $rose(hold_active) |-> ##[1:156] !hold_active)
    else $error("conversion too long");
  AST_VREF_PIN: assert property (
    s_w1_alone |=> ref_bandgap_sel == $past(sfr_wdata[2], 2))
    else $error("reference select wrong");
  AST_INPUT_PIN: assert property (
    s_w2_alone |=> input_second_sel == $past(sfr_wdata[0], 2))
    else $error("input select wrong");
endmodule : actm_asserts
bind actm_top actm_asserts chk_u (.clock, .reset_n, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .cmp_in, .dac_code, .hold_active,
  .input_second_sel, .ref_bandgap_sel, .th_a_en, .th_b_en,
  .limit_irq_line_n);

// File: test/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top
  import actm_pkg::*;
;
  typedef struct packed {
    logic       inv, sel, just;
    logic [7:0] thl, thh;
    logic [9:0] vin;
    logic       hi, lo;
  } actm_row_t;
  logic                clock = 1'h0;
  logic                reset_n = 1'h0;
  logic                sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic [7:0]          sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v;
  logic                cmp_in, hold_active, input_second_sel;
  logic                ref_bandgap_sel, th_a_en, th_b_en, limit_irq_line_n;
  logic [RESULT_W-1:0] dac_code, vin_a = '0, vin_b = '0;
  int                  bad_count = 0, checks = 0, n;
  actm_row_t           r;
  actm_row_t           rows [9] = '{
    '{1'h0,1'h0,1'h0,8'h10,8'hF0,10'h200,1'h0,1'h0},
    '{1'h0,1'h1,1'h1,8'h10,8'h40,10'h3FC,1'h1,1'h0},
    '{1'h0,1'h0,1'h1,8'h80,8'hF0,10'h004,1'h0,1'h1},
    '{1'h0,1'h1,1'h0,8'hFF,8'h00,10'h200,1'h1,1'h1},
    '{1'h0,1'h0,1'h0,8'h00,8'hFF,10'h3FF,1'h0,1'h0},
    '{1'h0,1'h0,1'h1,8'h80,8'h80,10'h202,1'h0,1'h0},
    '{1'h1,1'h1,1'h0,8'h40,8'h80,10'h100,1'h1,1'h1},
    '{1'h1,1'h0,1'h1,8'h40,8'h80,10'h204,1'h0,1'h0},
    '{1'h1,1'h1,1'h1,8'h80,8'h80,10'h200,1'h1,1'h1}};
  int                  divs [5] = '{8832, 4416, 2208, 1104, 552};
  logic [2:0]          codes [5] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h2};
  always #12.5 clock = ~clock;
  actm_top dut_u (.clock, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .cmp_in, .dac_code, .hold_active,
    .input_second_sel, .ref_bandgap_sel, .th_a_en, .th_b_en,
    .limit_irq_line_n);
  actm_afe afe_u (.vin_a, .vin_b, .dac_code, .input_second_sel,
    .hold_active, .cmp_in);
  task automatic summarize;
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_cnt
  task automatic tick;
    @(posedge clock);
    #2;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    tick();
    sfr_wr = 1'h0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'h1;
    tick();
    sfr_rd = 1'h0;
    tick();
    d = sfr_rdata;
  endtask : rd
  task automatic wait_idle(output logic [7:0] d);
    int k;
    k = 0;
    d = 8'h01;
    while (d[0] !== 1'h0 && k < 100) begin
      rd(ADDR_CON1, d);
      k++;
    end
    if (d[0] !== 1'h0) begin
      bad_count++;
      summarize();
    end
  endtask : wait_idle
  task automatic gap(input int lim, output int c);
    c = 0;
    while (hold_active === 1'h1 && c < lim) begin
      tick();
      c++;
    end
    while (hold_active !== 1'h1 && c < lim) begin
      tick();
      c++;
    end
  endtask : gap
  initial begin
    repeat (3) tick();
    reset_n = 1'h1;
    for (logic [7:0] a = 8'hE2; a != 8'hE9; a++) begin
      rd(a, v);
      cmp_reg(v, 8'h00);
    end
    cmp_reg({7'h00, limit_irq_line_n}, 8'h01);
    foreach (rows[i]) begin
      r = rows[i];
      vin_a = r.sel ? ~r.vin : r.vin;
      vin_b = r.sel ? r.vin : ~r.vin;
      wr(ADDR_THRL, r.thl);
      wr(ADDR_THRH, r.thh);
      wr(ADDR_CON2, {r.just, 6'h06, r.sel});
      wr(ADDR_CON1, {4'h0, r.inv, 3'h5});
      wait_idle(v);
      cmp_reg(v, {1'h0, r.hi, 1'h0, r.lo, r.inv, 3'h4});
      cmp_reg({7'h00, limit_irq_line_n}, {7'h00, !(r.hi | r.lo)});
      rd(ADDR_BUFH, v);
      cmp_reg(v, r.just ? {6'h00, r.vin[9:8]} : r.vin[9:2]);
      rd(ADDR_BUFL, v);
      cmp_reg(v, r.just ? r.vin[7:0] : {r.vin[1:0], 6'h00});
      wr(ADDR_CON1, 8'hA0);
      rd(ADDR_CON1, v);
      cmp_reg(v, 8'h00);
    end
    wr(ADDR_THRL, 8'hFF);
    wr(ADDR_THRH, 8'h00);
    wr(ADDR_CON1, 8'h05);
    wait_idle(v);
    cmp_reg(v, 8'h54);
    wr(ADDR_CON1, 8'h84);
    rd(ADDR_CON1, v);
    cmp_reg(v, 8'h14);
    cmp_reg({7'h00, limit_irq_line_n}, 8'h00);
    wr(ADDR_CON1, 8'h24);
    rd(ADDR_CON1, v);
    cmp_reg(v, 8'h04);
    cmp_reg({7'h00, limit_irq_line_n}, 8'h01);
    cmp_reg({5'h00, ref_bandgap_sel, th_a_en, th_b_en}, 8'h07);
    wr(ADDR_CON2, 8'h00);
    wr(ADDR_CON1, 8'h00);
    cmp_reg({5'h00, ref_bandgap_sel, th_a_en, th_b_en}, 8'h00);
    foreach (divs[i]) begin
      wr(ADDR_CON1, 8'h00);
      wr(ADDR_CON2, {1'h0, codes[i], 4'hC});
      wr(ADDR_CON1, 8'h02);
      gap(9000, n);
      gap(9000, n);
      cmp_cnt(n, divs[i]);
    end
    wr(ADDR_CON2, 8'h2E);
    wait_idle(v);
    cmp_reg(v, 8'h52);
    cmp_reg({5'h00, ref_bandgap_sel, th_a_en, th_b_en}, 8'h00);
    wr(ADDR_CON1, 8'h00);
    gap(1200, n);
    cmp_cnt(n, 1200);
    wr(ADDR_CON1, 8'h05);
    reset_n = 1'h0;
    tick();
    reset_n = 1'h1;
    rd(ADDR_CON1, v);
    cmp_reg(v, 8'h00);
    cmp_reg({5'h00, ref_bandgap_sel, th_a_en, th_b_en}, 8'h00);
    summarize();
  end
endmodule : tb_top
